// file: common/agccs_pkg.sv
package agccs_pkg;

  // Printed offsets are register indices; byte address is four times that.
  localparam logic [15:0] IDX_GAIN_LIMITS  = 16'hDF17;
  localparam logic [15:0] IDX_ORDER_THRESH = 16'hDF18;
  localparam logic [15:0] IDX_AGC_STATUS   = 16'hDF3F;
  localparam int          ADDR_W           = 20;

  localparam logic [7:0] RST_GAIN_LIMITS  = 8'h03;
  localparam logic [7:0] RST_ORDER_THRESH = 8'h40;
  localparam logic [7:0] ORDER_THRESH_RW  = 8'h7F;

  localparam int DIG_CEIL_LSB  = 6;
  localparam int FE_CEIL_LSB   = 3;
  localparam int SETPOINT_LSB  = 0;
  localparam int ORDER_BIT     = 6;
  localparam int REL_THR_LSB   = 4;
  localparam int ABS_THR_LSB   = 0;

  localparam logic [3:0] ABS_THR_OFF = 4'h8;
  localparam logic [2:0] DIG_RED_MAX = 3'h7;
  localparam logic [1:0] FE1_RED_MAX = 2'h3;
  localparam logic [2:0] FE2_RED_MAX = 3'h4;
  localparam logic [3:0] STEP_DB     = 4'h3;
  localparam logic [7:0] HYST_DB     = 8'h02;

  typedef struct packed {
    logic [2:0] dig;
    logic [1:0] fe1;
    logic [2:0] fe2;
  } agccs_gain_s;

  typedef struct packed {
    logic [1:0] dig_ceiling;
    logic [2:0] fe_ceiling;
    logic [2:0] setpoint;
  } agccs_limits_s;

  typedef struct packed {
    logic       order;
    logic [1:0] rel_thr;
    logic [3:0] abs_thr;
  } agccs_thresh_s;

  localparam agccs_gain_s GAIN_RST = '{dig: 3'h0, fe1: 2'h0, fe2: 3'h0};

  function automatic logic [7:0] setpoint_db(input logic [2:0] code);
    case (code)
      3'h0: setpoint_db = 8'h18;
      3'h1: setpoint_db = 8'h1B;
      3'h2: setpoint_db = 8'h1E;
      3'h3: setpoint_db = 8'h21;
      3'h4: setpoint_db = 8'h24;
      3'h5: setpoint_db = 8'h26;
      3'h6: setpoint_db = 8'h28;
      default: setpoint_db = 8'h2A;
    endcase
  endfunction

  function automatic logic [3:0] fe_total(input agccs_gain_s g);
    fe_total = {2'h0, g.fe1} + {1'b0, g.fe2};
  endfunction

endpackage

// file: src/agccs_strength.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational view of the receive level seen by the threshold logic.
module agccs_strength (
  input  wire logic                    [7:0] amp_db,
  input  wire agccs_pkg::agccs_gain_s        gain,
  input  wire agccs_pkg::agccs_limits_s      limits,
  output logic                         [9:0] strength,
  output logic                         [7:0] target_db
);

  logic [3:0] fe_red;
  logic [3:0] agc_steps;

  always_comb begin
    fe_red    = agccs_pkg::fe_total(gain);
    // Steps forced by the ceilings are not AGC reductions.
    agc_steps = ({1'b0, gain.dig} - {2'h0, limits.dig_ceiling})
              + (fe_red - {1'b0, limits.fe_ceiling});
    strength  = {2'h0, amp_db}
              + 10'(agc_steps) * 10'(agccs_pkg::STEP_DB);
    target_db = agccs_pkg::setpoint_db(limits.setpoint);
  end

endmodule
`default_nettype wire

// file: src/agccs_carrier_sense.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_carrier_sense (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       sample_valid,
  input  wire logic                 [9:0] strength,
  input  wire logic                 [7:0] target_db,
  input  wire agccs_pkg::agccs_thresh_s   thresh,
  output logic                            carrier_sense
);

  logic        [9:0]  ref_level;
  logic        [9:0]  rel_delta;
  logic signed [11:0] abs_level;
  logic               abs_met;
  logic               rel_met;

  always_comb begin
    case (thresh.rel_thr)
      2'h1: rel_delta = 10'h006;
      2'h2: rel_delta = 10'h00A;
      default: rel_delta = 10'h00E;
    endcase
    abs_level = $signed({4'h0, target_db})
              + {{8{thresh.abs_thr[3]}}, thresh.abs_thr};
    abs_met = (thresh.abs_thr != agccs_pkg::ABS_THR_OFF)
            && ($signed({2'b00, strength}) >= abs_level);
    rel_met = (thresh.rel_thr != 2'h0)
            && ({1'b0, strength} >= {1'b0, ref_level} + {1'b0, rel_delta});
  end

  // The reference follows the level only while no carrier is seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_level <= 10'h000;
    end else if (sample_valid && !carrier_sense) begin
      ref_level <= strength;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_sense <= 1'b0;
    end else if (sample_valid) begin
      carrier_sense <= abs_met || rel_met;
    end
  end

endmodule
`default_nettype wire

// file: src/agccs_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_cfg (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [agccs_pkg::ADDR_W-1:0] paddr,
  input  wire logic                [31:0] pwdata,
  output logic                     [31:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       amp_valid,
  input  wire logic                 [7:0] amp_db,
  output agccs_pkg::agccs_gain_s          gain_reduction,
  output logic                      [7:0] target_db,
  output logic                      [9:0] signal_strength,
  output logic                            carrier_sense
);

  // Register storage.
  agccs_pkg::agccs_limits_s limits;
  agccs_pkg::agccs_thresh_s thresh;

  // Bus decode.
  logic        setup_phase;
  logic        access_done;
  logic [15:0] reg_index;
  logic        sel_limits;
  logic        sel_thresh;
  logic        sel_status;
  logic        sel_mapped;
  logic [31:0] next_prdata;

  // AGC state.
  agccs_pkg::agccs_gain_s gain;
  agccs_pkg::agccs_gain_s next_gain;
  agccs_pkg::agccs_gain_s lowered;
  agccs_pkg::agccs_gain_s raised;
  logic [3:0]  fe_red;
  logic [2:0]  dig_floor;
  logic [3:0]  fe_floor;
  logic        too_high;
  logic        too_low;
  logic [9:0]  strength;
  logic [7:0]  target;
  logic [7:0]  floor_margin;

  // Address decode works on the word index; the two low bits are ignored.
  function automatic logic [15:0] word_index(
    input logic [agccs_pkg::ADDR_W-1:0] addr
  );
    word_index = addr[17:2];
  endfunction

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign reg_index   = word_index(paddr);
  assign sel_limits  = (reg_index == agccs_pkg::IDX_GAIN_LIMITS);
  assign sel_thresh  = (reg_index == agccs_pkg::IDX_ORDER_THRESH);
  assign sel_status  = (reg_index == agccs_pkg::IDX_AGC_STATUS);
  assign sel_mapped  = (sel_limits || sel_thresh || sel_status)
                       && (paddr[agccs_pkg::ADDR_W-1:18] == 2'h0);

  // Read mux is evaluated in the setup cycle so prdata is a flop output.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_limits) begin
      next_prdata[7:0] = limits;
    end else if (sel_thresh) begin
      next_prdata[7:0] = {1'b0, thresh};
    end else if (sel_status) begin
      next_prdata[7:0]   = gain;
      next_prdata[8]     = carrier_sense;
      next_prdata[25:16] = strength;
    end
  end

  // Zero wait states: pready rises in the access cycle of every transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      // Writes to the status word are refused like unmapped addresses.
      pslverr <= !sel_mapped || (pwrite && sel_status);
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite && sel_mapped) begin
      prdata <= next_prdata;
    end else if (setup_phase) begin
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limits <= agccs_pkg::RST_GAIN_LIMITS;
    end else if (access_done && pwrite && sel_limits) begin
      limits <= pwdata[7:0];
    end
  end

  // Bit 7 of the threshold word is not implemented and reads as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh <= agccs_pkg::RST_ORDER_THRESH[6:0];
    end else if (access_done && pwrite && sel_thresh) begin
      thresh <= pwdata[6:0] & agccs_pkg::ORDER_THRESH_RW[6:0];
    end
  end

  agccs_strength u_strength (
    .amp_db    (amp_db),
    .gain      (gain),
    .limits    (limits),
    .strength  (strength),
    .target_db (target)
  );

  // Ceilings appear as minimum reductions the AGC may never go below.
  always_comb begin
    dig_floor = {1'b0, limits.dig_ceiling};
    fe_floor  = {1'b0, limits.fe_ceiling};
    fe_red    = agccs_pkg::fe_total(gain);
  end

  // A small dead band keeps the loop from toggling on every sample.
  always_comb begin
    floor_margin = target - agccs_pkg::HYST_DB;
    too_high     = amp_db > target;
    too_low      = (target >= agccs_pkg::HYST_DB)
                   && (amp_db < floor_margin);
  end

  // Lowering gain: the front end goes first in the programmed order, then
  // the digital stage once the front end is at its minimum.
  always_comb begin
    lowered = gain;
    if (fe_red < {1'b0, agccs_pkg::FE1_RED_MAX} + {1'b0, agccs_pkg::FE2_RED_MAX}) begin
      if (thresh.order) begin
        if (gain.fe1 < agccs_pkg::FE1_RED_MAX) begin
          lowered.fe1 = gain.fe1 + 2'h1;
        end else begin
          lowered.fe2 = gain.fe2 + 3'h1;
        end
      end else begin
        if (gain.fe2 < agccs_pkg::FE2_RED_MAX) begin
          lowered.fe2 = gain.fe2 + 3'h1;
        end else begin
          lowered.fe1 = gain.fe1 + 2'h1;
        end
      end
    end else if (gain.dig < agccs_pkg::DIG_RED_MAX) begin
      lowered.dig = gain.dig + 3'h1;
    end
  end

  // Raising gain undoes the lowering in reverse order, never above a ceiling.
  always_comb begin
    raised = gain;
    if (gain.dig > dig_floor) begin
      raised.dig = gain.dig - 3'h1;
    end else if (fe_red > fe_floor) begin
      if (thresh.order) begin
        if (gain.fe2 != 3'h0) begin
          raised.fe2 = gain.fe2 - 3'h1;
        end else begin
          raised.fe1 = gain.fe1 - 2'h1;
        end
      end else begin
        if (gain.fe1 != 2'h0) begin
          raised.fe1 = gain.fe1 - 2'h1;
        end else begin
          raised.fe2 = gain.fe2 - 3'h1;
        end
      end
    end
  end

  // A newly written digital ceiling is applied at once, even with no sample present;
  // the front end moves one step per cycle until it reaches its ceiling.
  always_comb begin
    next_gain = gain;
    if (amp_valid && too_high) begin
      next_gain = lowered;
    end else if (amp_valid && too_low) begin
      next_gain = raised;
    end
    if (next_gain.dig < dig_floor) begin
      next_gain.dig = dig_floor;
    end
    // Only the front-end fields step here, so the digital floor above holds.
    if (agccs_pkg::fe_total(next_gain) < fe_floor) begin
      next_gain.fe1 = lowered.fe1;
      next_gain.fe2 = lowered.fe2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain <= agccs_pkg::GAIN_RST;
    end else begin
      gain <= next_gain;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reduction <= agccs_pkg::GAIN_RST;
    end else begin
      gain_reduction <= gain;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_db <= 8'h00;
    end else begin
      target_db <= target;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_strength <= 10'h000;
    end else if (amp_valid) begin
      signal_strength <= strength;
    end
  end

  agccs_carrier_sense u_cs (
    .pclk          (pclk),
    .presetn       (presetn),
    .sample_valid  (amp_valid),
    .strength      (strength),
    .target_db     (target),
    .thresh        (thresh),
    .carrier_sense (carrier_sense)
  );

endmodule
`default_nettype wire

// file: verification/agccs_cfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module agccs_cfg_chk (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [agccs_pkg::ADDR_W-1:0]   paddr,
  input wire logic                    [31:0] prdata,
  input wire logic                           pready,
  input wire logic                           pslverr,
  input wire logic                           amp_valid,
  input wire agccs_pkg::agccs_gain_s         gain_reduction,
  input wire logic                     [9:0] signal_strength,
  input wire logic                           carrier_sense
);
  logic hit;
  assign hit = paddr == 20'h37C5C || paddr == 20'h37C60 || paddr == 20'h37CFC;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  unmapped_err_a: assert property (psel && !penable && !hit |=> pslverr)
    else $error("unmapped access not refused");
  mapped_read_ok_a: assert property (psel && !penable && hit && !pwrite
    |=> !pslverr) else $error("mapped read refused");
  write_rdata_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  upper_bits_zero_a: assert property (
    pready && !pwrite && paddr != 20'h37CFC
    |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  sense_hold_a: assert property (!amp_valid |=> $stable(carrier_sense))
    else $error("carrier sense moved without sample");
  level_hold_a: assert property (!amp_valid |=> $stable(signal_strength))
    else $error("strength moved without sample");
  stage_two_range_a: assert property (gain_reduction.fe2 <= 3'h4)
    else $error("second stage reduction too deep");
  cover property (carrier_sense);
  cover property (pready && pslverr);
  cover property (gain_reduction.fe1 == 2'h3);
endmodule
bind agccs_cfg agccs_cfg_chk i_agccs_cfg_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .amp_valid,
  .gain_reduction, .signal_strength, .carrier_sense);
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic                  pwrite = 0, amp_valid = 0, pready, pslverr, er;
  logic                  carrier_sense;
  logic           [19:0] paddr = '0;
  logic           [31:0] pwdata = '0, prdata, rd, v;
  logic            [7:0] amp_db = '0, target_db, a;
  logic            [9:0] signal_strength;
  logic            [3:0] t;
  agccs_pkg::agccs_gain_s gain_reduction;
  int                    mismatches = 0, compares = 0;
  localparam logic [19:0] LIM = 20'h37C5C, THR = 20'h37C60, STS = 20'h37CFC;
  localparam logic [7:0] SP[8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26,
                                   8'h28, 8'h2A};
  localparam logic [7:0] REL[4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};
  agccs_cfg i_agccs_cfg (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .amp_valid, .amp_db,
    .gain_reduction, .target_db, .signal_strength, .carrier_sense);
  initial forever #20 pclk = ~pclk;
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_f(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [19:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // The idle amplitude is random so only the valid pulse may be trusted.
  task automatic pulse(input logic [7:0] x);
    @(posedge pclk);
    amp_valid <= 1;
    amp_db <= x;
    @(posedge pclk);
    amp_valid <= 0;
    amp_db <= 8'($urandom);
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic cs_abs(input logic [7:0] x, input logic [3:0] th);
    return th != 4'h8 && int'(x) >= 33 + int'($signed(th));
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    void'($urandom(66));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, LIM, 0);
    chk_v(rd, 32'h03);
    apb(0, THR, 0);
    chk_v(rd, 32'h40);
    chk_v(target_db, 8'h21);
    for (int c = 0; c < 8; c++) begin
      apb(1, LIM, c);
      apb(0, LIM, 0);
      chk_v(target_db, SP[c]);
    end
    repeat (4) begin
      v = $urandom;
      apb(1, THR, v);
      apb(0, THR, 0);
      chk_v(rd, {24'h0, v[7:0] & 8'h7F});
    end
    apb(0, 20'h00010, 32'h0);
    chk_f(er, 1'b1);
    apb(1, STS, 32'hFF);
    chk_f(er, 1'b1);
    $display("register tests done");
    apb(1, LIM, 32'h03);
    // Amplitudes stay at or below the target, so gain is never cut.
    repeat (24) begin
      t = 4'($urandom);
      a = 8'(20 + $urandom % 14);
      apb(1, THR, {28'h4, t});
      pulse(a);
      chk_v(signal_strength, a);
      chk_f(carrier_sense, cs_abs(a, t));
    end
    apb(1, THR, 32'h48);
    pulse(8'd33);
    chk_f(carrier_sense, 1'b0);
    $display("absolute tests done");
    apb(1, LIM, 32'h07);
    for (int c = 0; c < 4; c++) begin
      apb(1, THR, 32'h48 | (c << 4));
      pulse(8'd20);
      pulse(8'd20);
      pulse(c ? 8'(20 + REL[c] - 1) : 8'd41);
      chk_f(carrier_sense, 1'b0);
      pulse(8'd20);
      pulse(8'd20);
      pulse(c ? 8'(20 + REL[c]) : 8'd41);
      chk_f(carrier_sense, c != 0);
    end
    $display("relative tests done");
    apb(1, LIM, 32'h00);
    for (int o = 0; o < 2; o++) begin
      apb(1, THR, (o << 6) | 8);
      repeat (5) pulse(8'h3C);
      chk_v(gain_reduction, o ? 8'h1A : 8'h0C);
      repeat (12) pulse(8'h0A);
      chk_v(gain_reduction, 8'h00);
    end
    apb(1, LIM, 32'hF8);
    // The front end steps once per cycle up to its floor, so allow it time.
    repeat (12) @(posedge pclk);
    chk_v(gain_reduction.dig, 3'h3);
    chk_v(gain_reduction.fe1 + gain_reduction.fe2, 32'h7);
    $display("gain tests done");
    wrap_up();
  end
endmodule
`default_nettype wire
